/* File: pdpm_pkg.sv */
// Package with constants and types for the DMA performance monitor
package pdpm_pkg;

	// ************************************************************
	// Register map (word index times four)
	// ************************************************************
	localparam logic [7:0] OFS_ENG0_C2S = 8'h00;
	localparam logic [7:0] OFS_ENG1_C2S = 8'h04;
	localparam logic [7:0] OFS_ENG0_S2C = 8'h08;
	localparam logic [7:0] OFS_ENG1_S2C = 8'h0C;
	localparam logic [7:0] OFS_TX_UTIL = 8'h10;
	localparam logic [7:0] OFS_RX_UTIL = 8'h14;
	localparam logic [7:0] OFS_TX_PAY = 8'h18;
	localparam logic [7:0] OFS_RX_PAY = 8'h1C;
	localparam logic [7:0] OFS_CONTROL = 8'h20;
	localparam logic [7:0] OFS_STATUS = 8'h24;
	localparam logic [31:0] RESET_VALUE = 32'h0000_0000;
	localparam int CONTROL_MONITOR_EN_BIT = 0;
	localparam int STATUS_FIFO_FULL_BIT = 0;
	localparam int STATUS_FIFO_EMPTY_BIT = 1;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_PERIOD_NS = 10;
	localparam longint INTERVAL_NS = 64'd1000000000;
	localparam int INTERVAL_CYCLES = int'(INTERVAL_NS / CLK_PERIOD_NS);

	// ************************************************************
	// Transaction layer fields
	// ************************************************************
	localparam logic [1:0] FMT_NO_DATA_3DW = 2'h0;
	localparam logic [6:0] TYPE_MEM_WRITE = 7'h40;
	localparam logic [6:0] TYPE_COMPLETION = 7'h4A;

	// One beat of a 64-bit transaction interface
	typedef struct packed {
		logic valid;
		logic ready;
		logic sop;
		logic eop;
		logic [7:0] keep;
		logic [63:0] data;
	} pdpm_beat_t;

	// One beat of a user streaming interface
	typedef struct packed {
		logic valid;
		logic ready;
		logic [7:0] keep;
	} pdpm_stream_t;

	typedef enum logic [1:0] {
		PDPM_IDLE = 2'h0,
		PDPM_HDR = 2'h1,
		PDPM_BODY = 2'h3
	} pdpm_pkt_state_t;

endpackage

/* File: pdpm_fifo.sv */
// Snapshot FIFO between the interval timer and software reads
`timescale 1ns/100ps
module pdpm_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 32
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	output logic full,
	output logic empty
);
	localparam int AW = $clog2(DEPTH);

	if (DEPTH < 2 || (1 << AW) != DEPTH) begin
		$error("pdpm_fifo depth must be a power of two");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr;
	logic [AW:0] rd_ptr;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;

	assign full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
	assign empty = wr_ptr == rd_ptr;
	assign in_ready = !full;
	assign out_valid = !empty;
	assign out_data = mem[rd_ptr[AW-1:0]];

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr[AW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			wr_ptr <= wr_ptr + (AW+1)'(push);
			rd_ptr <= rd_ptr + (AW+1)'(pop);
		end
	end
endmodule

/* File: pdpm_monitor.sv */
// Performance counters for a packet DMA on a 64-bit PCIe transaction interface
// How it works
// - Card_to_system engine fetches descriptor, then writes payload to host buffer.
// - System_to_card engine fetches descriptor, then reads buffer and takes completions.
// - After each buffer, engine issues one descriptor update write.
// - Descriptor fetch returns 32 bytes as one completion payload.
// - Card_to_system descriptor update write carries 12 bytes of status.
// - With 64-byte completion boundary, two completions per 128-byte read are accepted.
// - Writes obey negotiated max payload; reads obey negotiated max read request.
// - Two card_to_system and two system_to_card engines, one pair per path.
// - With both paths active, bandwidth is shared per direction.
// - Each engine counts payload bytes delivered on its user stream.
// - Transmit utilization counts every outbound byte, headers included.
// - Receive utilization counts every inbound byte, headers included.
// - Transmit payload counts only upstream memory write payload.
// - Receive payload counts only downstream completion payload.
// - The eight counter registers refresh once per second with a full interval.
// - Counters watch 64-bit interface and handle unaligned data.
`timescale 1ns/100ps
module pdpm_monitor #(
	parameter int INTERVAL = pdpm_pkg::INTERVAL_CYCLES,
	parameter int ENGINES = 4,
	parameter int FIFO_DEPTH = 32
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [31:0] reg_rdata,
	input wire pdpm_pkg::pdpm_beat_t outbound_txn_port,
	input wire pdpm_pkg::pdpm_beat_t inbound_txn_port,
	input wire pdpm_pkg::pdpm_stream_t [3:0] engine_stream,
	output logic interval_tick
);
	// ************************************************************
	// Parameter checks
	// ************************************************************
	if (ENGINES != 4) begin
		$error("pdpm_monitor serves exactly two engine pairs");
	end
	if (INTERVAL < 2) begin
		$error("pdpm_monitor interval too short");
	end

	// ************************************************************
	// Helper functions
	// ************************************************************
	function automatic logic [3:0] keep_bytes(input logic [7:0] keep);
		logic [3:0] n;
		n = 4'h0;
		for (int i = 0; i < 8; i++) begin
			n = n + {3'h0, keep[i]};
		end
		return n;
	endfunction

	// Saturating add keeps a busy interval from wrapping to a small value
	function automatic logic [31:0] sat_add(input logic [31:0] acc, input logic [3:0] inc);
		logic [32:0] s;
		s = {1'b0, acc} + {29'h0, inc};
		return s[32] ? 32'hFFFF_FFFF : s[31:0];
	endfunction

	// ************************************************************
	// Control register and interval timer
	// ************************************************************
	logic monitor_en;
	logic [31:0] tick_count;
	wire ctrl_write = reg_write && (reg_addr == pdpm_pkg::OFS_CONTROL);
	wire tick = monitor_en && (tick_count == 32'(INTERVAL - 1));
	assign interval_tick = tick;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			monitor_en <= 1'b1;
		end else if (ctrl_write) begin
			monitor_en <= reg_wdata[pdpm_pkg::CONTROL_MONITOR_EN_BIT];
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			tick_count <= 32'h0000_0000;
		end else if (!monitor_en || tick) begin
			tick_count <= 32'h0000_0000;
		end else begin
			tick_count <= tick_count + 32'h0000_0001;
		end
	end

	// ************************************************************
	// Packet tracking on the transaction interfaces
	// ************************************************************
	// The first beat of a 3DW header carries DW0/DW1, the second DW2 and the first
	// data DW, so payload starts mid-beat: only the upper half of beat two counts.
	pdpm_pkg::pdpm_pkt_state_t tx_state;
	pdpm_pkg::pdpm_pkt_state_t rx_state;
	logic tx_is_write;
	logic rx_is_cpl;
	wire tx_take = outbound_txn_port.valid && outbound_txn_port.ready;
	wire rx_take = inbound_txn_port.valid && inbound_txn_port.ready;
	logic tx_hdr4_q;
	wire tx_sop_write = outbound_txn_port.data[30] && (outbound_txn_port.data[28:24] == 5'h00);
	wire rx_sop_cpl = inbound_txn_port.data[30] && (inbound_txn_port.data[28:24] == 5'h0A);
	wire tx_hdr4 = outbound_txn_port.data[29];
	// Header size is only readable on the start beat, so beat two uses the held flag
	wire [7:0] tx_pay_keep = (tx_state == pdpm_pkg::PDPM_HDR)
		? (tx_hdr4_q ? 8'h00 : {outbound_txn_port.keep[7:4], 4'h0})
		: outbound_txn_port.keep;
	wire [7:0] rx_pay_keep = (rx_state == pdpm_pkg::PDPM_HDR)
		? {inbound_txn_port.keep[7:4], 4'h0}
		: inbound_txn_port.keep;
	wire tx_count_pay = tx_take && tx_is_write && (tx_state != pdpm_pkg::PDPM_IDLE);
	wire rx_count_pay = rx_take && rx_is_cpl && (rx_state != pdpm_pkg::PDPM_IDLE);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			tx_state <= pdpm_pkg::PDPM_IDLE;
			tx_is_write <= 1'b0;
			tx_hdr4_q <= 1'b0;
		end else if (tx_take) begin
			if (outbound_txn_port.sop && !outbound_txn_port.eop) begin
				tx_state <= pdpm_pkg::PDPM_HDR;
				tx_is_write <= tx_sop_write;
				tx_hdr4_q <= tx_hdr4;
			end else if (outbound_txn_port.eop) begin
				tx_state <= pdpm_pkg::PDPM_IDLE;
			end else begin
				tx_state <= pdpm_pkg::PDPM_BODY;
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rx_state <= pdpm_pkg::PDPM_IDLE;
			rx_is_cpl <= 1'b0;
		end else if (rx_take) begin
			if (inbound_txn_port.sop && !inbound_txn_port.eop) begin
				rx_state <= pdpm_pkg::PDPM_HDR;
				rx_is_cpl <= rx_sop_cpl;
			end else if (inbound_txn_port.eop) begin
				rx_state <= pdpm_pkg::PDPM_IDLE;
			end else begin
				rx_state <= pdpm_pkg::PDPM_BODY;
			end
		end
	end

	// 4DW-header writes hold no data in beat two; payload begins on beat three
	wire [7:0] tx_keep_eff = (tx_state == pdpm_pkg::PDPM_HDR && tx_hdr4_q) ? 8'h00 : tx_pay_keep;

	// ************************************************************
	// Running counters
	// ************************************************************
	// Index 0..3 engines, 4 tx util, 5 rx util, 6 tx payload, 7 rx payload
	logic [31:0] run [8];
	logic [31:0] snap [8];
	logic [3:0] inc [8];

	always_comb begin
		for (int i = 0; i < 4; i++) begin
			inc[i] = (engine_stream[i].valid && engine_stream[i].ready)
				? keep_bytes(engine_stream[i].keep) : 4'h0;
		end
		inc[4] = tx_take ? keep_bytes(outbound_txn_port.keep) : 4'h0;
		inc[5] = rx_take ? keep_bytes(inbound_txn_port.keep) : 4'h0;
		inc[6] = tx_count_pay ? keep_bytes(tx_keep_eff) : 4'h0;
		inc[7] = rx_count_pay ? keep_bytes(rx_pay_keep) : 4'h0;
	end

	// A tick restarts the sum with this cycle's beat, so no count falls between
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < 8; i++) begin
				run[i] <= pdpm_pkg::RESET_VALUE;
				snap[i] <= pdpm_pkg::RESET_VALUE;
			end
		end else begin
			for (int i = 0; i < 8; i++) begin
				if (tick) begin
					snap[i] <= run[i];
					run[i] <= {28'h0, inc[i]};
				end else if (monitor_en) begin
					run[i] <= sat_add(run[i], inc[i]);
				end
			end
		end
	end

	// ************************************************************
	// Tick history FIFO
	// ************************************************************
	// Holds total transmit utilization per interval; a status read pops one entry
	logic hist_valid;
	logic hist_ready;
	logic [31:0] hist_data;
	logic hist_full;
	logic hist_empty;
	logic hist_in_ready;
	wire status_read = reg_read && (reg_addr == pdpm_pkg::OFS_STATUS);
	assign hist_ready = status_read;

	pdpm_fifo #(
		.WIDTH(32),
		.DEPTH(FIFO_DEPTH)
	) u_hist (
		.clk(clk),
		.resetn(resetn),
		.in_valid(tick),
		.in_ready(hist_in_ready),
		.in_data(run[4]),
		.out_valid(hist_valid),
		.out_ready(hist_ready),
		.out_data(hist_data),
		.full(hist_full),
		.empty(hist_empty)
	);

	// ************************************************************
	// Register read port
	// ************************************************************
	logic [31:0] rd_mux;
	always_comb begin
		case (reg_addr)
			pdpm_pkg::OFS_ENG0_C2S: rd_mux = snap[0];
			pdpm_pkg::OFS_ENG1_C2S: rd_mux = snap[1];
			pdpm_pkg::OFS_ENG0_S2C: rd_mux = snap[2];
			pdpm_pkg::OFS_ENG1_S2C: rd_mux = snap[3];
			pdpm_pkg::OFS_TX_UTIL: rd_mux = snap[4];
			pdpm_pkg::OFS_TX_PAY: rd_mux = snap[6];
			pdpm_pkg::OFS_RX_UTIL: rd_mux = snap[5];
			pdpm_pkg::OFS_RX_PAY: rd_mux = snap[7];
			pdpm_pkg::OFS_CONTROL: rd_mux = {31'h0, monitor_en};
			pdpm_pkg::OFS_STATUS: rd_mux = hist_valid ? hist_data : 32'h0000_0000;
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_read) begin
			reg_rdata <= rd_mux;
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end

	wire unused_ok = hist_full ^ hist_empty ^ hist_in_ready ^ (|reg_wdata[31:1]);
endmodule

/* File: pdpm_monitor_chk.sv */
// Port checker for the DMA performance monitor, with its bind
`timescale 1ns/100ps
module pdpm_monitor_chk #(
	parameter int INTERVAL = pdpm_pkg::INTERVAL_CYCLES
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [31:0] reg_rdata,
	input wire pdpm_pkg::pdpm_beat_t outbound_txn_port,
	input wire logic interval_tick
);
	// ****
	// Reference timer and transmit utilization
	// ****
	logic en;
	logic [31:0] cnt;
	logic [31:0] run;
	logic [31:0] snap;
	wire logic take = en && outbound_txn_port.valid && outbound_txn_port.ready;
	wire logic [31:0] add = take ? 32'($countones(outbound_txn_port.keep)) : 32'h0;
	default clocking @(posedge clk);
	endclocking
	default disable iff (!resetn);
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			en <= 1'b1;
			cnt <= 32'h0;
			run <= 32'h0;
			snap <= 32'h0;
		end else begin
			if (reg_write && reg_addr == pdpm_pkg::OFS_CONTROL) begin
				en <= reg_wdata[0];
			end
			cnt <= (!en || cnt == 32'(INTERVAL - 1)) ? 32'h0 : cnt + 32'h1;
			run <= interval_tick ? add : run + add;
			snap <= interval_tick ? run : snap;
		end
	end
	AST_RDATA_IDLE: assert property (!$past(reg_read) |-> reg_rdata == 32'h0) else $error("stray rdata");
	AST_UNMAPPED: assert property (reg_read && reg_addr > 8'h24 |=> reg_rdata == 32'h0) else $error("unmapped");
	AST_TICK_EXACT: assert property (interval_tick == (en && cnt == 32'(INTERVAL - 1))) else $error("tick");
	AST_TICK_OFF: assert property (!en |-> !interval_tick) else $error("tick while off");
	AST_TX_UTIL: assert property (reg_read && reg_addr == pdpm_pkg::OFS_TX_UTIL |=> reg_rdata == $past(snap))
		else $error("tx utilization");
	AST_CTRL: assert property (reg_read && reg_addr == pdpm_pkg::OFS_CONTROL |=> reg_rdata == {31'h0, $past(en)})
		else $error("control");
	AST_RESTART: assert property ($rose(en) |-> (!interval_tick) [*8]) else $error("early tick");
	AST_TICK_GAP: assert property (interval_tick |=> (!interval_tick) [*8]) else $error("tick gap");
	cover property (interval_tick);
	cover property (reg_read && reg_addr == pdpm_pkg::OFS_TX_UTIL ##1 reg_rdata != 32'h0);
	cover property (reg_write && reg_addr == pdpm_pkg::OFS_CONTROL && !reg_wdata[0]);
endmodule
bind pdpm_monitor pdpm_monitor_chk #(.INTERVAL(INTERVAL)) pdpm_monitor_chk_inst (.clk(clk), .resetn(resetn),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
	.outbound_txn_port(outbound_txn_port), .interval_tick(interval_tick));

/* File: pdpm_link_model.sv */
// Link partner model driving both transaction ports
`timescale 1ns/100ps
module pdpm_link_model (
	input wire logic clk,
	input wire logic resetn,
	input wire logic send_wr,
	input wire logic send_cpl,
	input wire logic stall,
	input wire logic no_data,
	output pdpm_pkg::pdpm_beat_t outbound,
	output pdpm_pkg::pdpm_beat_t inbound
);
	// ****
	// Packet sequencers
	// ****
	logic [2:0] wr_n;
	logic [2:0] cpl_n;
	logic [63:0] idle;
	wire logic wr_on = wr_n != 3'h0;
	wire logic cpl_on = cpl_n != 3'h0;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wr_n <= 3'h0;
			cpl_n <= 3'h0;
			idle <= 64'h0;
		end else begin
			// Idle lanes toggle so a stale beat never repeats
			idle <= ~idle;
			if (wr_on ? !stall : send_wr) begin
				wr_n <= (wr_n == 3'h3) ? 3'h0 : wr_n + 3'h1;
			end
			if (cpl_on || send_cpl) begin
				cpl_n <= (cpl_n == 3'h6) ? 3'h0 : cpl_n + 3'h1;
			end
		end
	end
	assign outbound = '{valid: wr_on, ready: !stall, sop: wr_n == 3'h1, eop: wr_n == 3'h3, keep: wr_on ? 8'hFF : idle[7:0],
		data: (wr_n == 3'h1) ? {32'h0, no_data ? 32'h0000_0003 : 32'h4000_0003} : idle};
	// Last beat half full, so the count must not assume whole words
	assign inbound = '{valid: cpl_on, ready: 1'b1, sop: cpl_n == 3'h1, eop: cpl_n == 3'h6,
		keep: (cpl_n == 3'h6) ? 8'h0F : cpl_on ? 8'hFF : idle[7:0], data: (cpl_n == 3'h1) ? 64'h0000_0020_4A00_0008 : idle};
endmodule

/* File: pdpm_monitor_test.sv */
// Self-checking bench for the DMA performance monitor
`timescale 1ns/100ps
module pdpm_monitor_test;
	localparam int IV = 40;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic write = 1'b0;
	logic read = 1'b0;
	logic [31:0] rdata;
	logic tick;
	logic send_wr = 1'b0;
	logic send_cpl = 1'b0;
	logic stall = 1'b0;
	logic no_data = 1'b0;
	pdpm_pkg::pdpm_beat_t ob;
	pdpm_pkg::pdpm_beat_t ib;
	pdpm_pkg::pdpm_stream_t [3:0] es = '0;
	int errors = 0;
	int checks_done = 0;
	// Address in the top byte, expected snapshot below
	logic [39:0] rows [10] = '{40'h00_0000_0001, 40'h04_0000_0004, 40'h08_0000_0006, 40'h0C_0000_0008,
		40'h10_0000_0018, 40'h14_0000_002C, 40'h18_0000_000C, 40'h1C_0000_0020, 40'h28_0000_0000, 40'h30_0000_0000};
	always #5 clk = ~clk;
	pdpm_link_model pdpm_link_model_inst (.clk(clk), .resetn(resetn), .send_wr(send_wr), .send_cpl(send_cpl),
		.stall(stall), .no_data(no_data), .outbound(ob), .inbound(ib));
	pdpm_monitor #(.INTERVAL(IV)) pdpm_monitor_inst (.clk(clk), .resetn(resetn), .reg_addr(addr), .reg_wdata(wdata),
		.reg_write(write), .reg_read(read), .reg_rdata(rdata), .outbound_txn_port(ob), .inbound_txn_port(ib),
		.engine_stream(es), .interval_tick(tick));
	// ****
	// Tasks
	// ****
	task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		read <= 1'b1;
		addr <= a;
		@(posedge clk);
		read <= 1'b0;
		#1 cmp_word(rdata, exp);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		write <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		write <= 1'b0;
	endtask
	task automatic wait_tick();
		int n;
		n = 0;
		while (tick !== 1'b1 && n < 2 * IV) begin
			@(negedge clk);
			n++;
		end
		cmp_word({31'h0, tick}, 32'h1);
		@(posedge clk);
	endtask
	task automatic traffic(input logic cpl);
		@(posedge clk);
		send_wr <= 1'b1;
		send_cpl <= cpl;
		@(posedge clk);
		send_wr <= 1'b0;
		send_cpl <= 1'b0;
		stall <= cpl;
		@(posedge clk);
		stall <= 1'b0;
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// ****
	// Sequence
	// ****
	initial begin
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		foreach (rows[i]) rd(rows[i][39:32], 32'h0);
		rd(pdpm_pkg::OFS_CONTROL, 32'h1);
		$display("reset values done");
		wait_tick();
		repeat (33) begin
			traffic(1'b0);
			wait_tick();
		end
		rd(pdpm_pkg::OFS_STATUS, 32'h0);
		repeat (31) rd(pdpm_pkg::OFS_STATUS, 32'h18);
		repeat (3) rd(pdpm_pkg::OFS_STATUS, 32'h0);
		$display("history buffer done");
		traffic(1'b1);
		es <= {4{10'h2FF}};
		@(posedge clk);
		es <= {10'h3FF, 10'h33F, 10'h30F, 10'h301};
		@(posedge clk);
		es <= {4{10'h2A5}};
		wr(pdpm_pkg::OFS_TX_UTIL, 32'hFFFF_FFFF);
		wait_tick();
		foreach (rows[i]) rd(rows[i][39:32], rows[i][31:0]);
		$display("traffic rows done");
		wr(pdpm_pkg::OFS_CONTROL, 32'h0);
		repeat (2 * IV) begin
			@(negedge clk);
			cmp_word({31'h0, tick}, 32'h0);
		end
		rd(pdpm_pkg::OFS_CONTROL, 32'h0);
		wr(pdpm_pkg::OFS_CONTROL, 32'h1);
		wait_tick();
		$display("monitor enable done");
		no_data <= 1'b1;
		traffic(1'b0);
		wait_tick();
		rd(pdpm_pkg::OFS_TX_UTIL, 32'h18);
		rd(pdpm_pkg::OFS_TX_PAY, 32'h0);
		$display("read request done");
		summarize();
	end
	initial begin
		#100000;
		errors++;
		summarize();
	end
endmodule
